// [src/hltc_defs.svh]
`ifndef HLTC_DEFS_SVH
`define HLTC_DEFS_SVH

// Register indices; the byte address is four times the index.
`define HLTC_IDX_SAMPLE   6'h29
`define HLTC_IDX_CAL      6'h2A
`define HLTC_IDX_STATUS   6'h2B
`define HLTC_IDX_OPEN     6'h2C

// Reset values.
`define HLTC_RST_SAMPLE   8'h0C
`define HLTC_RST_CAL      8'h02
`define HLTC_RST_OPEN     8'h00

// Field positions.
`define HLTC_ZCW_LSB      0
`define HLTC_SMP_LSB      2
`define HLTC_CALT_LSB     0
`define HLTC_SHAPE_BIT    0
`define HLTC_OLCNT_LSB    5
`define HLTC_AUTO_BIT     7

// Codes and counts.
`define HLTC_CAL_TRIG     2'h3
`define HLTC_OL_BASE      3'h3
`define HLTC_MISS_MAX     3'h7

// Times in their own units.
`define HLTC_CLK_MHZ      250
`define HLTC_ZCW_US0      100
`define HLTC_ZCW_US1      200
`define HLTC_ZCW_US2      300
`define HLTC_ZCW_US3      390
`define HLTC_SMP_US0      150
`define HLTC_SMP_US1      200
`define HLTC_SMP_US2      250
`define HLTC_SMP_US3      300
`define HLTC_CAL_MS0      250
`define HLTC_CAL_MS1      500
`define HLTC_CAL_MS2      1000

// Cycle counts derived from the times; all divide exactly at this rate.
`define HLTC_US_CYC(t)    ((t) * `HLTC_CLK_MHZ)
`define HLTC_MS_CYC(t)    ((t) * 1000 * `HLTC_CLK_MHZ)

`endif

// [src/hltc_pkg.sv]
package hltc_pkg;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN  = 2'b01,
    CAL_MEAS = 2'b10
  } hltc_cal_st_t;

endpackage

// [src/hltc_tmr_if.sv]
interface hltc_tmr_if #(
  parameter int TW = 28
);
  logic          load;
  logic [TW-1:0] count;
  logic          busy;
  logic          expire;

  modport ctl (output load, output count, input busy, input expire);
  modport tmr (input load, input count, output busy, output expire);
endinterface

// [src/hltc_timer.sv]
module hltc_timer #(
  parameter int TW = 28
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control side
  hltc_tmr_if.tmr  t
);

  logic [TW-1:0] cnt_reg;
  logic          expire_reg;

  // A load restarts the count; expire pulses count cycles after the load.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (t.load) begin
      cnt_reg <= t.count;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expire_reg <= 1'b0;
    end else begin
      expire_reg <= !t.load && (cnt_reg == {{(TW-1){1'b0}}, 1'b1});
    end
  end

  assign t.busy   = (cnt_reg != '0);
  assign t.expire = expire_reg;

endmodule

// [src/hltc_top.sv]
`include "hltc_defs.svh"

// What this block does
// RULE1: Window code 0 to 3 picks 100, 200, 300 or 390 us; resets to 0.
// RULE2: Calibration code 0, 1, 2 gives 250, 500, 1000 ms; resets to 2.
// RULE3: Fixed calibration runs long enough to settle at rated drive level.
// RULE4: Code 3 calibrates until an external, enable or software trigger.
// RULE5: Host keeps trigger-ended calibration running at least one second.
// RULE6: After the ending trigger, measurements finish before calibration ends.
// RULE7: Back-EMF sample waits 150, 200, 250 or 300 us; resets to 3.
// RULE8: Enabled fallback forces square open-loop drive after enough misses.
// RULE9: Fallback count code 0 to 3 means 3 to 6 missed attempts.
// RULE10: Open-loop shape bit selects square at 0 and sine at 1.
// RULE11: Reserved bits reset to zero, read back, and steer nothing.
module hltc_top #(
  parameter int unsigned TW       = 28,
  parameter int unsigned ZCW_CYC0 = `HLTC_US_CYC(`HLTC_ZCW_US0),
  parameter int unsigned ZCW_CYC1 = `HLTC_US_CYC(`HLTC_ZCW_US1),
  parameter int unsigned ZCW_CYC2 = `HLTC_US_CYC(`HLTC_ZCW_US2),
  parameter int unsigned ZCW_CYC3 = `HLTC_US_CYC(`HLTC_ZCW_US3),
  parameter int unsigned SMP_CYC0 = `HLTC_US_CYC(`HLTC_SMP_US0),
  parameter int unsigned SMP_CYC1 = `HLTC_US_CYC(`HLTC_SMP_US1),
  parameter int unsigned SMP_CYC2 = `HLTC_US_CYC(`HLTC_SMP_US2),
  parameter int unsigned SMP_CYC3 = `HLTC_US_CYC(`HLTC_SMP_US3),
  parameter int unsigned CAL_CYC0 = `HLTC_MS_CYC(`HLTC_CAL_MS0),
  parameter int unsigned CAL_CYC1 = `HLTC_MS_CYC(`HLTC_CAL_MS1),
  parameter int unsigned CAL_CYC2 = `HLTC_MS_CYC(`HLTC_CAL_MS2)
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Trigger pins, asynchronous
  input  wire logic          ext_trig_pin,
  input  wire logic          enable_pin,
  // Drive engine requests
  input  wire logic          sw_trig,
  input  wire logic          cal_start,
  input  wire logic          meas_done,
  input  wire logic          drive_active,
  input  wire logic          zc_event,
  input  wire logic          zc_ok,
  input  wire logic          zc_miss,
  // Drive engine results
  output logic               cal_running,
  output logic               cal_measuring,
  output logic               cal_done,
  output logic               adc_sample,
  output logic      [TW-1:0] zc_window_cyc,
  output logic               fallback_active,
  output logic               drive_sine
);

  generate
    if (TW < 2 || TW > 31 ||
        ZCW_CYC0 < 1 || ZCW_CYC3 >= (1 << TW) ||
        SMP_CYC0 < 1 || SMP_CYC3 >= (1 << TW) ||
        CAL_CYC0 < 1 || CAL_CYC2 >= (1 << TW)) begin : g_bad_param
      $error("hltc_top: a cycle count does not fit the timer width");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0]  sample_reg;
  logic [7:0]  cal_reg;
  logic [7:0]  open_reg;
  logic [7:0]  status_rd;
  logic [5:0]  idx;
  logic        hit;
  logic        wr_en;
  logic [31:0] prdata_reg;
  logic [31:0] rd_next;
  assign idx   = paddr[7:2];
  assign hit   = (idx == `HLTC_IDX_SAMPLE) || (idx == `HLTC_IDX_CAL) ||
                 (idx == `HLTC_IDX_STATUS) || (idx == `HLTC_IDX_OPEN);
  assign wr_en = psel && penable && pwrite && hit;
  // Reserved bits are stored and read back only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_reg <= `HLTC_RST_SAMPLE; // see RULE1 see RULE7 see RULE11
      cal_reg    <= `HLTC_RST_CAL;    // see RULE2 see RULE11
      open_reg   <= `HLTC_RST_OPEN;   // see RULE11
    end else if (wr_en) begin
      case (idx)
        `HLTC_IDX_SAMPLE: sample_reg <= pwdata[7:0];
        `HLTC_IDX_CAL:    cal_reg    <= pwdata[7:0];
        `HLTC_IDX_OPEN:   open_reg   <= pwdata[7:0];
        default:          sample_reg <= sample_reg;
      endcase
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    case (idx)
      `HLTC_IDX_SAMPLE: rd_next[7:0] = sample_reg;
      `HLTC_IDX_CAL:    rd_next[7:0] = cal_reg;
      `HLTC_IDX_STATUS: rd_next[7:0] = status_rd;
      `HLTC_IDX_OPEN:   rd_next[7:0] = open_reg;
      default:          rd_next      = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup cycle so the answer needs no wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger pin synchronisers
  logic [1:0] pin_s1_reg;
  logic [1:0] pin_s2_reg;
  logic [1:0] pin_s3_reg;
  logic       any_trig;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 2'h0;
      pin_s2_reg <= 2'h0;
      pin_s3_reg <= 2'h0;
    end else begin
      pin_s1_reg <= {enable_pin, ext_trig_pin};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  assign any_trig = sw_trig || ((pin_s2_reg & ~pin_s3_reg) != 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Calibration sequencer
  hltc_tmr_if #(.TW(TW)) cal_t ();
  hltc_timer #(.TW(TW)) u_cal_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (cal_t)
  );

  hltc_pkg::hltc_cal_st_t cal_st_reg;
  logic                   trig_mode_reg;
  logic                   cal_done_reg;
  logic [1:0]             cal_code;
  assign cal_code = cal_reg[`HLTC_CALT_LSB +: 2];
  always_comb begin
    case (cal_code)
      2'h0:    cal_t.count = TW'(CAL_CYC0); // see RULE2
      2'h1:    cal_t.count = TW'(CAL_CYC1); // see RULE2
      default: cal_t.count = TW'(CAL_CYC2); // see RULE2
    endcase
  end

  assign cal_t.load = (cal_st_reg == hltc_pkg::CAL_IDLE) && cal_start &&
                      (cal_code != `HLTC_CAL_TRIG);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_st_reg    <= hltc_pkg::CAL_IDLE;
      trig_mode_reg <= 1'b0;
    end else begin
      case (cal_st_reg)
        hltc_pkg::CAL_IDLE: begin
          if (cal_start) begin
            cal_st_reg    <= hltc_pkg::CAL_RUN;
            trig_mode_reg <= (cal_code == `HLTC_CAL_TRIG); // see RULE4
          end
        end
        hltc_pkg::CAL_RUN: begin
          // Trigger mode ends only on a trigger; the host owns its length.
          if (trig_mode_reg ? any_trig : cal_t.expire) begin // see RULE4
            cal_st_reg <= hltc_pkg::CAL_MEAS; // see RULE6
          end
        end
        hltc_pkg::CAL_MEAS: begin
          if (meas_done) begin // see RULE6
            cal_st_reg <= hltc_pkg::CAL_IDLE;
          end
        end
        default: cal_st_reg <= hltc_pkg::CAL_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_done_reg <= 1'b0;
    end else begin
      cal_done_reg <= (cal_st_reg == hltc_pkg::CAL_MEAS) && meas_done;
    end
  end

  // The engine drives at the rated level for the whole run phase.
  assign cal_running   = (cal_st_reg == hltc_pkg::CAL_RUN); // see RULE3
  assign cal_measuring = (cal_st_reg == hltc_pkg::CAL_MEAS);
  assign cal_done      = cal_done_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Crossing window and back-EMF sample delay
  hltc_tmr_if #(.TW(TW)) smp_t ();
  hltc_timer #(.TW(TW)) u_smp_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (smp_t)
  );
  logic [TW-1:0] zcw_reg;
  always_comb begin
    case (sample_reg[`HLTC_SMP_LSB +: 2])
      2'h0:    smp_t.count = TW'(SMP_CYC0); // see RULE7
      2'h1:    smp_t.count = TW'(SMP_CYC1); // see RULE7
      2'h2:    smp_t.count = TW'(SMP_CYC2); // see RULE7
      default: smp_t.count = TW'(SMP_CYC3); // see RULE7
    endcase
  end
  assign smp_t.load = zc_event;
  assign adc_sample = smp_t.expire; // see RULE7
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zcw_reg <= TW'(ZCW_CYC0); // see RULE1
    end else begin
      case (sample_reg[`HLTC_ZCW_LSB +: 2])
        2'h0:    zcw_reg <= TW'(ZCW_CYC0); // see RULE1
        2'h1:    zcw_reg <= TW'(ZCW_CYC1); // see RULE1
        2'h2:    zcw_reg <= TW'(ZCW_CYC2); // see RULE1
        default: zcw_reg <= TW'(ZCW_CYC3); // see RULE1
      endcase
    end
  end

  assign zc_window_cyc = zcw_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Open-loop fallback and drive shape
  logic [2:0] miss_reg;
  logic [2:0] miss_limit;
  logic       fallback_reg;
  logic       sine_reg;

  assign miss_limit = `HLTC_OL_BASE +
                      {1'b0, open_reg[`HLTC_OLCNT_LSB +: 2]}; // see RULE9

  // A miss in the same cycle as a good crossing counts as a miss.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miss_reg <= 3'h0;
    end else if (!drive_active) begin
      miss_reg <= 3'h0;
    end else if (zc_miss) begin
      if (miss_reg != `HLTC_MISS_MAX) begin
        miss_reg <= miss_reg + 3'h1;
      end
    end else if (zc_ok) begin
      miss_reg <= 3'h0;
    end
  end

  // Fallback holds until the drive stops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fallback_reg <= 1'b0;
    end else if (!drive_active) begin
      fallback_reg <= 1'b0;
    end else if (open_reg[`HLTC_AUTO_BIT] && zc_miss &&
                 (miss_reg >= miss_limit - 3'h1)) begin // see RULE8
      fallback_reg <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sine_reg <= 1'b0;
    end else begin
      // Fallback drives square from the cycle after it sets, whatever the shape bit says.
      sine_reg <= open_reg[`HLTC_SHAPE_BIT] && !fallback_reg; // see RULE10
    end
  end

  assign fallback_active = fallback_reg;
  assign drive_sine      = sine_reg;

  assign status_rd = {2'h0, miss_reg, fallback_reg, cal_measuring, cal_running};

endmodule

// [sim/hltc_props.sv]
module hltc_props #(
  parameter int unsigned TW       = 28,
  parameter int unsigned ZCW_CYC0 = 10,
  parameter int unsigned ZCW_CYC1 = 20,
  parameter int unsigned ZCW_CYC2 = 30,
  parameter int unsigned ZCW_CYC3 = 40
) (
  // Clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  // Engine requests
  input wire logic          cal_start,
  input wire logic          meas_done,
  input wire logic          drive_active,
  input wire logic          zc_event,
  input wire logic          zc_miss,
  // Engine results
  input wire logic          cal_running,
  input wire logic          cal_measuring,
  input wire logic          cal_done,
  input wire logic          adc_sample,
  input wire logic [TW-1:0] zc_window_cyc,
  input wire logic          fallback_active,
  input wire logic          drive_sine
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_START_RUN: assert property (
    cal_start && !cal_running && !cal_measuring |=> cal_running)
    else $error("start did not begin a run");
  AST_ONE_PHASE: assert property (
    !(cal_running && cal_measuring))
    else $error("run and measure both active");
  AST_MEAS_AFTER_RUN: assert property (
    $rose(cal_measuring) |-> $past(cal_running))
    else $error("measure phase without a run");
  AST_DONE_AFTER_MEAS: assert property (
    cal_measuring && meas_done |=> cal_done && !cal_measuring)
    else $error("measure end not reported");
  AST_WINDOW_CODE: assert property (
    $changed(zc_window_cyc) |->
      zc_window_cyc inside {ZCW_CYC0, ZCW_CYC1, ZCW_CYC2, ZCW_CYC3})
    else $error("crossing window off the table");
  AST_SAMPLE_WAIT: assert property (
    zc_event |=> !adc_sample [*4])
    else $error("sample taken too soon");
  AST_FALL_CAUSE: assert property (
    $rose(fallback_active) |-> $past(zc_miss) && $past(drive_active))
    else $error("fallback without a miss");
  AST_FALL_SQUARE: assert property (
    fallback_active |=> !drive_sine)
    else $error("sine drive during fallback");
  AST_FALL_CLEAR: assert property (
    !drive_active |-> ##[1:2] !fallback_active)
    else $error("fallback kept while idle");

  cover property (cal_done);
  cover property (adc_sample);
  cover property ($rose(fallback_active));
endmodule

bind hltc_top hltc_props #(.TW(TW), .ZCW_CYC0(ZCW_CYC0),
  .ZCW_CYC1(ZCW_CYC1), .ZCW_CYC2(ZCW_CYC2), .ZCW_CYC3(ZCW_CYC3)) i_props (
  .pclk(pclk), .presetn(presetn), .cal_start(cal_start),
  .meas_done(meas_done), .drive_active(drive_active), .zc_event(zc_event),
  .zc_miss(zc_miss), .cal_running(cal_running),
  .cal_measuring(cal_measuring), .cal_done(cal_done),
  .adc_sample(adc_sample), .zc_window_cyc(zc_window_cyc),
  .fallback_active(fallback_active), .drive_sine(drive_sine));

// [sim/hltc_engine_model.sv]
module hltc_engine_model (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Engine handshake
  input  wire logic slow,
  input  wire logic cal_measuring,
  output logic      meas_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] wait_reg;

  // The slow setting stretches the final measurement to stress the wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_reg  <= 5'h00;
      meas_done <= 1'b0;
    end else begin
      meas_done <= 1'b0;
      if (!cal_measuring || meas_done) begin
        wait_reg <= 5'h00;
      end else if (wait_reg == (slow ? 5'h14 : 5'h03)) begin
        meas_done <= 1'b1;
      end else begin
        wait_reg <= wait_reg + 5'h01;
      end
    end
  end
endmodule

// [sim/tb.sv]
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned ZW [4] = '{10, 20, 30, 40};
  localparam int unsigned SM [4] = '{5, 6, 7, 8};
  // The last entry is the trigger run: the host's second at this scale.
  localparam int unsigned CL [4] = '{100, 200, 300, 300};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed, r;
  logic [2:0]  trg;
  logic        zc_ok;
  logic        cal_start, meas_done, drive_active, zc_event, zc_miss, slow;
  logic        cal_running, cal_measuring, cal_done, adc_sample;
  logic        fallback_active, drive_sine;
  logic [27:0] zc_window_cyc;
  logic [32:0] ex;
  logic [32:0] exp_q[$];
  int          err_count, comparisons, n, k;

  hltc_top #(.ZCW_CYC0(ZW[0]), .ZCW_CYC1(ZW[1]), .ZCW_CYC2(ZW[2]),
    .ZCW_CYC3(ZW[3]), .SMP_CYC0(SM[0]), .SMP_CYC1(SM[1]), .SMP_CYC2(SM[2]),
    .SMP_CYC3(SM[3]), .CAL_CYC0(CL[0]), .CAL_CYC1(CL[1]),
    .CAL_CYC2(CL[2])) i_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_trig_pin(trg[0]), .enable_pin(trg[1]),
    .sw_trig(trg[2]), .cal_start(cal_start), .meas_done(meas_done),
    .drive_active(drive_active), .zc_event(zc_event), .zc_ok(zc_ok),
    .zc_miss(zc_miss), .cal_running(cal_running),
    .cal_measuring(cal_measuring), .cal_done(cal_done),
    .adc_sample(adc_sample), .zc_window_cyc(zc_window_cyc),
    .fallback_active(fallback_active), .drive_sine(drive_sine));
  hltc_engine_model i_eng (.pclk(pclk), .presetn(presetn), .slow(slow),
    .cal_measuring(cal_measuring), .meas_done(meas_done));

  always #2 pclk = ~pclk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [32:0] e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // An idle edge keeps a following call from moving psel twice at once.
    @(posedge pclk);
  endtask

  task automatic step();
    @(posedge pclk);
    n++;
  endtask

  task automatic print_verdict();
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      ex = exp_q.pop_front();
      if (!pwrite) check("prdata", prdata, ex[31:0]);
      check("pslverr", pslverr, ex[32]);
    end
  end

  initial begin
    #200000;
    err_count++;
    print_verdict();
  end

  initial begin
    {pclk, psel, penable, pwrite, trg, cal_start, zc_event, zc_miss} = '0;
    {presetn, slow, zc_ok, paddr, pwdata} = '0;
    drive_active = 1'b1;
    seed = 32'hDBB71A0E;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("window", zc_window_cyc, 10);
    apb(0, 8'hA4, 0, 33'h0C);
    apb(0, 8'hA8, 0, 33'h02);
    apb(0, 8'hB0, 0, 33'h00);
    apb(1, 8'hC0, 0, {1'b1, 32'h0});
    apb(0, 8'hC0, 0, {1'b1, 32'h0});
    for (k = 0; k < 4; k++) begin
      r = (xs() & 32'hF0) | (k * 5);
      apb(1, 8'hA4, r, 33'h0);
      apb(0, 8'hA4, 0, {1'b0, r});
      repeat (2) @(posedge pclk);
      check("window", zc_window_cyc, 10 * (k + 1));
      zc_event <= 1'b1;
      @(posedge pclk);
      zc_event <= 1'b0;
      n = 0;
      do step(); while (adc_sample !== 1'b1 && n < 99);
      // The bench reads each output at the edge after the one that raised it.
      check("sample delay", n - 1, SM[k]);
    end
    // A trigger run lasts the scaled second that the host owes it.
    for (k = 0; k < 6; k++) begin
      slow <= k[0];
      apb(1, 8'hA8, (k > 2 ? 3 : k) | (xs() & 32'hFC), 33'h0);
      cal_start <= 1'b1;
      @(posedge pclk);
      cal_start <= 1'b0;
      n = 0;
      do begin
        step();
        trg <= (k > 2 && n == CL[3]) ? 3'h1 << (k - 3) : 3'h0;
      end while (cal_running === 1'b1 && n < 999);
      check("run length", n - CL[k > 2 ? 3 : k] <= 5, 1);
      check("measuring", cal_measuring, 1);
      n = 0;
      do step(); while (cal_done !== 1'b1 && n < 60);
      check("cal done", cal_done, 1);
    end
    for (k = 0; k < 4; k++) begin
      apb(1, 8'hB0, 32'h81 | (k << 5) | (xs() & 32'h1E), 33'h0);
      repeat (2) @(posedge pclk);
      check("sine", drive_sine, 1);
      // A good crossing must clear a miss, or fallback comes one miss early.
      zc_miss <= 1'b1;
      @(posedge pclk);
      zc_miss <= 1'b0;
      zc_ok <= 1'b1;
      @(posedge pclk);
      zc_ok <= 1'b0;
      repeat (k + 3) begin
        check("fallback", fallback_active, 0);
        zc_miss <= 1'b1;
        @(posedge pclk);
        zc_miss <= 1'b0;
        @(posedge pclk);
      end
      check("fallback", fallback_active, 1);
      @(posedge pclk);
      check("sine", drive_sine, 0);
      apb(0, 8'hAC, 0, {1'b0, 32'h4 | ((k + 3) << 3)});
      drive_active <= 1'b0;
      repeat (3) @(posedge pclk);
      drive_active <= 1'b1;
    end
    print_verdict();
  end
endmodule
